// File: core/mmsx_pkg.sv
/*
  Constants shared by the remote-control command interpreter and its bench.
  Assumes a byte-wide receive/transmit pair below the interpreter.
*/
package mmsx_pkg;
  // ****************************************************************
  // Message framing
  // ****************************************************************
  localparam logic [7:0] SOX        = 8'hF0;
  localparam logic [7:0] EOX        = 8'hF7;
  localparam logic [7:0] RT_MIN     = 8'hF8;
  localparam logic [7:0] BCAST_ADDR = 8'h7F;
  localparam int         HDR_LAST   = 6;

  // ****************************************************************
  // Message types
  // ****************************************************************
  localparam logic [7:0] TY_REQ_IFACE = 8'h10;
  localparam logic [7:0] TY_REQ_METER = 8'h11;
  localparam logic [7:0] TY_REQ_MIC   = 8'h40;
  localparam logic [7:0] TY_SET_IFACE = 8'h20;
  localparam logic [7:0] TY_SET_MIC   = 8'h22;
  localparam logic [7:0] TY_RSP_IFACE = 8'h30;
  localparam logic [7:0] TY_RSP_METER = 8'h31;
  localparam logic [7:0] TY_RSP_MIC   = 8'h32;

  // ****************************************************************
  // Parameter space
  // ****************************************************************
  localparam int         N_CH       = 8;
  localparam int         N_PARAMS   = 29;
  localparam int         N_SETTABLE = 18;
  localparam int         N_STATUS   = 6;
  localparam logic [6:0] GAIN_LAST  = 7'h0F;
  localparam logic [6:0] GAIN_MAX   = 7'h3F;
  localparam logic [6:0] PARAM_RST  = 7'h00;
  localparam logic [6:0] PEAK_RST   = 7'h00;

  typedef enum logic [1:0] {RK_IFACE, RK_METER, RK_MIC} mmsx_kind_t;
endpackage

// File: core/mmsx_param_mem.sv
/*
  Small store of settable parameter bytes with a registered read port.
  Assumes a single clock; one write and one read per cycle.
*/
`timescale 1ns/1ps
module mmsx_param_mem #(
  parameter int DEPTH = 18,
  parameter int WIDTH = 7,
  parameter int AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  // Reset keeps the first dump after power-up defined
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data <= mem_r[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end
endmodule

// File: core/mmsx_remote.sv
/*
  System exclusive remote-control interpreter: parses incoming messages, applies
  parameter writes, forwards microphone commands and answers dump requests.
  Assumes a byte receiver giving rx_valid pulses and a transmitter taking bytes on
  tx_valid && tx_ready; mic_rd_data answers mic_rd_ch/mic_rd_idx in the same cycle.
*/
// Notes on behaviour
// - Frame: F0, maker, model, address, type, body, F7
// - Address low nibble device, high nibble bank
// - Address 7Fh accepted by every device
// - 10h interface, 11h meters, 40h-47h microphone requests
// - Type 20h applies each number/value pair whose number is below 18 and, for a gain, whose value is 0..63
// - Type 22h carries four-byte microphone command groups
// - Interface request answered by one 30h dump
// - Microphone request answered by one 32h dump
// - Meter reply 31h: eight bytes, channel one first
// - Meter request sends only the meter reply
// - Peaks held until sent, then cleared
// - Gain accepts 0..63 only
`timescale 1ns/1ps
module mmsx_remote #(
  parameter logic [23:0] MAKER_ID = 24'h00_11_22, // Arbitrary value
  parameter logic [7:0]  MODEL_ID = 8'h5A,        // Arbitrary value
  parameter int          MIC_LEN  = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        tx_ready,
  input  wire logic [2:0]  cfg_bank,
  input  wire logic [2:0]  cfg_dev_id,
  input  wire logic [55:0] meter_level,
  input  wire logic        meter_valid,
  input  wire logic [41:0] status_bytes,
  input  wire logic [7:0]  mic_rd_data,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             par_wr_valid,
  output logic      [6:0]  par_wr_num,
  output logic      [6:0]  par_wr_val,
  output logic             mic_cmd_valid,
  output logic      [27:0] mic_cmd_word,
  output logic      [2:0]  mic_rd_ch,
  output logic      [7:0]  mic_rd_idx
);
  // ****************************************************************
  // Receive parser
  // ****************************************************************
  typedef enum logic [2:0] {P_IDLE, P_MAKER, P_MODEL, P_ADDR, P_TYPE, P_REQ, P_BODY, P_SKIP} mmsx_pst_t;
  typedef enum logic [2:0] {T_IDLE, T_HDR, T_FETCH, T_LOAD, T_EOX} mmsx_tst_t;

  mmsx_pst_t            p_state_r;
  mmsx_tst_t            t_state_r;
  logic [1:0]           cnt_r;
  logic                 body_mic_r;
  mmsx_pkg::mmsx_kind_t req_kind_r;
  logic [2:0]           req_ch_r;
  logic [6:0]           nn_r;
  logic [20:0]          grp_r;
  mmsx_pkg::mmsx_kind_t tx_kind_r;
  logic [7:0]           pos_r;
  logic [6:0]           peak_r [mmsx_pkg::N_CH];
  logic [6:0]           mem_rd;

  wire [7:0] own_addr   = {1'b0, cfg_bank, 1'b0, cfg_dev_id};
  wire       addr_ok    = (rx_data == mmsx_pkg::BCAST_ADDR) || (rx_data == own_addr);
  wire       rt_byte    = rx_data >= mmsx_pkg::RT_MIN;
  wire       data_byte  = rx_valid && !rx_data[7];
  wire       eox_in     = rx_valid && (rx_data == mmsx_pkg::EOX);
  wire [7:0] maker_byte = (cnt_r == 2'd0) ? MAKER_ID[23:16] : (cnt_r == 2'd1) ? MAKER_ID[15:8] : MAKER_ID[7:0];
  wire       tx_idle    = t_state_r == T_IDLE;
  // A request arriving while a reply is still going out is dropped
  wire       req_go     = (p_state_r == P_REQ) && eox_in && tx_idle;
  wire       is_gain    = (nn_r <= mmsx_pkg::GAIN_LAST) && !nn_r[0];
  wire       set_ok     = (int'(nn_r) < mmsx_pkg::N_SETTABLE) && (!is_gain || rx_data[6:0] <= mmsx_pkg::GAIN_MAX);
  wire       set_apply  = (p_state_r == P_BODY) && !body_mic_r && data_byte && cnt_r[0] && set_ok;
  wire       mic_apply  = (p_state_r == P_BODY) && body_mic_r && data_byte && (cnt_r == 2'd3);
  wire       is_req_mic = rx_data[7:3] == mmsx_pkg::TY_REQ_MIC[7:3];

  mmsx_pst_t p_state_nxt;
  always_comb begin
    p_state_nxt = p_state_r;
    if (rx_valid && !rt_byte) begin
      if (rx_data == mmsx_pkg::SOX) begin
        p_state_nxt = P_MAKER;
      end else if (rx_data[7]) begin
        p_state_nxt = P_IDLE;
      end else begin
        case (p_state_r)
          P_MAKER: begin
            if (rx_data != maker_byte) begin
              p_state_nxt = P_SKIP;
            end else if (cnt_r == 2'd2) begin
              p_state_nxt = P_MODEL;
            end
          end
          P_MODEL: p_state_nxt = (rx_data == MODEL_ID) ? P_ADDR : P_SKIP;
          P_ADDR:  p_state_nxt = addr_ok ? P_TYPE : P_SKIP;
          P_TYPE: begin
            if (rx_data == mmsx_pkg::TY_REQ_IFACE || rx_data == mmsx_pkg::TY_REQ_METER || is_req_mic) begin
              p_state_nxt = P_REQ;
            end else if (rx_data == mmsx_pkg::TY_SET_IFACE || rx_data == mmsx_pkg::TY_SET_MIC) begin
              p_state_nxt = P_BODY;
            end else begin
              p_state_nxt = P_SKIP;
            end
          end
          P_REQ:   p_state_nxt = P_SKIP;
          default: p_state_nxt = p_state_r;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p_state_r <= P_IDLE;
    end else begin
      p_state_r <= p_state_nxt;
    end
  end

  // Byte counter walks the maker code and the body groups
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'd0;
    end else if (rx_valid && rx_data == mmsx_pkg::SOX) begin
      cnt_r <= 2'd0;
    end else if (data_byte && (p_state_r == P_MAKER || p_state_r == P_BODY)) begin
      cnt_r <= (p_state_r == P_BODY && !body_mic_r) ? {1'b0, ~cnt_r[0]} : cnt_r + 2'd1;
    end else if (p_state_r == P_TYPE) begin
      cnt_r <= 2'd0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      body_mic_r <= 1'b0;
      req_kind_r <= mmsx_pkg::RK_IFACE;
      req_ch_r   <= 3'd0;
    end else if (p_state_r == P_TYPE && data_byte) begin
      body_mic_r <= rx_data == mmsx_pkg::TY_SET_MIC;
      req_kind_r <= is_req_mic ? mmsx_pkg::RK_MIC :
                    (rx_data == mmsx_pkg::TY_REQ_METER) ? mmsx_pkg::RK_METER : mmsx_pkg::RK_IFACE;
      req_ch_r   <= rx_data[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nn_r  <= 7'h00;
      grp_r <= 21'h00000;
    end else if (p_state_r == P_BODY && data_byte) begin
      nn_r  <= rx_data[6:0];
      grp_r <= {grp_r[13:0], rx_data[6:0]};
    end
  end

  // ****************************************************************
  // Parameter and microphone command outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_wr_valid  <= 1'b0;
      par_wr_num    <= 7'h00;
      par_wr_val    <= mmsx_pkg::PARAM_RST;
      mic_cmd_valid <= 1'b0;
      mic_cmd_word  <= 28'h0000000;
    end else begin
      par_wr_valid  <= set_apply;
      mic_cmd_valid <= mic_apply;
      if (set_apply) begin
        par_wr_num <= nn_r;
        par_wr_val <= rx_data[6:0];
      end
      if (mic_apply) begin
        mic_cmd_word <= {grp_r, rx_data[6:0]};
      end
    end
  end

  wire [6:0] pay_idx = pos_r[6:0];
  mmsx_param_mem #(.DEPTH(mmsx_pkg::N_SETTABLE), .WIDTH(7), .AW(5)) u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (set_apply),
    .wr_addr (nn_r[4:0]),
    .wr_data (rx_data[6:0]),
    .rd_addr (pay_idx[4:0]),
    .rd_data (mem_rd)
  );

  // ****************************************************************
  // Peak hold
  // ****************************************************************
  wire       slot_free = !tx_valid || tx_ready;
  wire       pay_load  = (t_state_r == T_LOAD) && slot_free;
  genvar ch;
  generate
    for (ch = 0; ch < mmsx_pkg::N_CH; ch++) begin : g_peak
      wire [6:0] lvl = meter_level[ch*7 +: 7];
      wire       clr = pay_load && (tx_kind_r == mmsx_pkg::RK_METER) && (pos_r == 8'(ch));
      // A level that lands in the clearing cycle starts the next hold
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          peak_r[ch] <= mmsx_pkg::PEAK_RST;
        end else if (clr) begin
          peak_r[ch] <= meter_valid ? lvl : mmsx_pkg::PEAK_RST;
        end else if (meter_valid && lvl > peak_r[ch]) begin
          peak_r[ch] <= lvl;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Reply transmitter
  // ****************************************************************
  wire [7:0] pay_last  = (tx_kind_r == mmsx_pkg::RK_METER) ? 8'(mmsx_pkg::N_CH - 1) :
                         (tx_kind_r == mmsx_pkg::RK_MIC)   ? 8'(MIC_LEN - 1) : 8'(mmsx_pkg::N_PARAMS - 1);
  wire [7:0] rsp_type  = (tx_kind_r == mmsx_pkg::RK_METER) ? mmsx_pkg::TY_RSP_METER :
                         (tx_kind_r == mmsx_pkg::RK_MIC)   ? mmsx_pkg::TY_RSP_MIC : mmsx_pkg::TY_RSP_IFACE;
  wire [2:0] hdr_pos   = pos_r[2:0];
  wire [7:0] hdr_byte  = (hdr_pos == 3'd0) ? mmsx_pkg::SOX : (hdr_pos == 3'd1) ? MAKER_ID[23:16] :
                         (hdr_pos == 3'd2) ? MAKER_ID[15:8] : (hdr_pos == 3'd3) ? MAKER_ID[7:0] :
                         (hdr_pos == 3'd4) ? MODEL_ID : (hdr_pos == 3'd5) ? own_addr : rsp_type;
  wire [6:0] stat_idx  = pay_idx - 7'(mmsx_pkg::N_SETTABLE);
  wire [6:0] stat_byte = (int'(stat_idx) < mmsx_pkg::N_STATUS) ? status_bytes[stat_idx[2:0]*7 +: 7] : 7'h00;
  wire [6:0] if_byte   = (int'(pay_idx) < mmsx_pkg::N_SETTABLE) ? mem_rd : stat_byte;
  // Bit 7 forced low: a payload byte must never pass for a status byte
  wire [7:0] pay_byte  = (tx_kind_r == mmsx_pkg::RK_METER) ? {1'b0, peak_r[pos_r[2:0]]} :
                         (tx_kind_r == mmsx_pkg::RK_MIC) ? {1'b0, mic_rd_data[6:0]} : {1'b0, if_byte};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_state_r <= T_IDLE;
      pos_r     <= 8'h00;
      tx_kind_r <= mmsx_pkg::RK_IFACE;
    end else begin
      case (t_state_r)
        T_IDLE: begin
          pos_r <= 8'h00;
          if (req_go) begin
            t_state_r <= T_HDR;
            tx_kind_r <= req_kind_r;
          end
        end
        T_HDR: begin
          if (slot_free) begin
            pos_r     <= (pos_r == 8'(mmsx_pkg::HDR_LAST)) ? 8'h00 : pos_r + 8'h01;
            t_state_r <= (pos_r == 8'(mmsx_pkg::HDR_LAST)) ? T_FETCH : T_HDR;
          end
        end
        // Fetch gives the registered store read one cycle to settle
        T_FETCH: t_state_r <= T_LOAD;
        T_LOAD: begin
          if (slot_free) begin
            pos_r     <= pos_r + 8'h01;
            t_state_r <= (pos_r == pay_last) ? T_EOX : T_FETCH;
          end
        end
        T_EOX:   t_state_r <= slot_free ? T_IDLE : T_EOX;
        default: t_state_r <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      mic_rd_ch  <= 3'd0;
      mic_rd_idx <= 8'h00;
    end else begin
      if (req_go) begin
        mic_rd_ch <= req_ch_r;
      end
      if (t_state_r == T_FETCH) begin
        mic_rd_idx <= pos_r;
      end
      if (slot_free && (t_state_r == T_HDR || t_state_r == T_LOAD || t_state_r == T_EOX)) begin
        tx_valid <= 1'b1;
        tx_data  <= (t_state_r == T_HDR) ? hdr_byte : (t_state_r == T_LOAD) ? pay_byte : mmsx_pkg::EOX;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_sox_first;
    @(posedge clk) disable iff (!rst_n)
      (t_state_r == T_HDR && pos_r == 8'h00 && slot_free) |=> (tx_valid && tx_data == mmsx_pkg::SOX);
  endproperty
  a_sox_first: assert property (p_sox_first) else $error("Reply did not open with F0");

  property p_own_addr;
    @(posedge clk) disable iff (!rst_n)
      (p_state_r == P_ADDR && rx_valid && rx_data == own_addr) |=> (p_state_r == P_TYPE);
  endproperty
  a_own_addr: assert property (p_own_addr) else $error("Own address not accepted");

  property p_bcast;
    @(posedge clk) disable iff (!rst_n)
      (p_state_r == P_ADDR && rx_valid && rx_data == mmsx_pkg::BCAST_ADDR) |=> (p_state_r == P_TYPE);
  endproperty
  a_bcast: assert property (p_bcast) else $error("Broadcast address not accepted");

  property p_foreign;
    @(posedge clk) disable iff (!rst_n)
      (p_state_r == P_ADDR && data_byte && !addr_ok) |=> (p_state_r == P_SKIP) ##1 (tx_idle || !$rose(!tx_idle));
  endproperty
  a_foreign: assert property (p_foreign) else $error("Foreign address not discarded");

  property p_iface_reply;
    @(posedge clk) disable iff (!rst_n)
      (req_go && req_kind_r == mmsx_pkg::RK_IFACE) |=> (t_state_r == T_HDR && tx_kind_r == mmsx_pkg::RK_IFACE);
  endproperty
  a_iface_reply: assert property (p_iface_reply) else $error("Interface request not answered");

  property p_set_pair;
    @(posedge clk) disable iff (!rst_n)
      (p_state_r == P_BODY && !body_mic_r && data_byte && cnt_r == 2'd1 && int'(nn_r) < mmsx_pkg::N_SETTABLE
       && rx_data[6:0] <= mmsx_pkg::GAIN_MAX) |=> (par_wr_valid && par_wr_val == $past(rx_data[6:0]));
  endproperty
  a_set_pair: assert property (p_set_pair) else $error("Parameter pair not applied");

  property p_gain_range;
    @(posedge clk) disable iff (!rst_n)
      (par_wr_valid && par_wr_num <= mmsx_pkg::GAIN_LAST && !par_wr_num[0]) |-> (par_wr_val <= mmsx_pkg::GAIN_MAX);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("Gain write above 63");

  property p_mic_group;
    @(posedge clk) disable iff (!rst_n)
      mic_apply |=> (mic_cmd_valid && mic_cmd_word == {$past(grp_r), $past(rx_data[6:0])});
  endproperty
  a_mic_group: assert property (p_mic_group) else $error("Microphone group not forwarded");

  property p_mic_byte;
    @(posedge clk) disable iff (!rst_n)
      (pay_load && tx_kind_r == mmsx_pkg::RK_MIC) |=> (tx_valid && tx_data == {1'b0, $past(mic_rd_data[6:0])});
  endproperty
  a_mic_byte: assert property (p_mic_byte) else $error("Microphone byte not sent as data byte");

  property p_meter_len;
    @(posedge clk) disable iff (!rst_n)
      (pay_load && tx_kind_r == mmsx_pkg::RK_METER && pos_r == 8'h07) |=> (t_state_r == T_EOX);
  endproperty
  a_meter_len: assert property (p_meter_len) else $error("Meter reply not eight bytes");

  property p_peak_clear;
    @(posedge clk) disable iff (!rst_n)
      (pay_load && tx_kind_r == mmsx_pkg::RK_METER && pos_r == 8'h00 && !meter_valid)
        |=> (peak_r[0] == mmsx_pkg::PEAK_RST);
  endproperty
  a_peak_clear: assert property (p_peak_clear) else $error("Peak not cleared after send");

  c_meter_reply: cover property (@(posedge clk) disable iff (!rst_n)
                                 (t_state_r == T_EOX && tx_kind_r == mmsx_pkg::RK_METER));
  c_mic_reply:   cover property (@(posedge clk) disable iff (!rst_n)
                                 (t_state_r == T_EOX && tx_kind_r == mmsx_pkg::RK_MIC));
  c_set_write:   cover property (@(posedge clk) disable iff (!rst_n) par_wr_valid);
  c_mic_cmd:     cover property (@(posedge clk) disable iff (!rst_n) mic_cmd_valid);
endmodule

// File: verif/mmsx_host_model.sv
/*
  Remote controller model: takes reply bytes from the interpreter's transmit side.
  Assumes one clock; stall makes tx_ready toggle every cycle.
*/
`timescale 1ns/1ps
module mmsx_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       stall,
  output logic            tx_ready
);
  // ****************************************************************
  // Byte capture
  // ****************************************************************
  logic [7:0] got [0:255];
  int         cnt;
  logic       tog_r;
  // Slow controller accepts only every other cycle
  assign tx_ready = stall ? tog_r : 1'b1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_r <= 1'b0;
      cnt   <= 0;
    end else begin
      tog_r <= ~tog_r;
      if (tx_valid && tx_ready) begin
        got[cnt[7:0]] <= tx_data;
        cnt           <= cnt + 1;
      end
    end
  end
endmodule

// File: verif/mmsx_remote_bench.sv
/*
  Self-checking bench for the remote-control interpreter.
  Assumes the host model in its own file; bank 3, device 5.
*/
`timescale 1ns/1ps
module mmsx_remote_bench;
  // ****************************************************************
  // Stimulus and monitors
  // ****************************************************************
  localparam logic [23:0] MK   = 24'h001122;
  localparam logic [7:0]  MD   = 8'h5A;
  localparam logic [7:0]  ADDR = 8'h35;
  localparam int          ML   = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_valid = 1'b0;
  logic        meter_valid = 1'b0;
  logic        stall = 1'b0;
  logic [55:0] meter_level = 56'h0;
  logic [41:0] status_bytes = 42'h0;
  logic [7:0]  tx_data, mic_rd_data, mic_rd_idx;
  logic        tx_valid, tx_ready, par_wr_valid, mic_cmd_valid;
  logic [6:0]  par_wr_num, par_wr_val, last_num, last_val;
  logic [27:0] mic_cmd_word, last_cmd;
  logic [2:0]  mic_rd_ch;
  logic [7:0]  nob [$];
  int          mismatches = 0;
  int          check_count = 0;
  int          wr_cnt = 0;
  int          cmd_cnt = 0;
  int          base = 0;
  // Bit 7 set on purpose: the reply must carry only the low seven bits
  assign mic_rd_data = {1'b1, mic_rd_ch, mic_rd_idx[3:0]};
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (par_wr_valid === 1'b1) begin
      wr_cnt++;
      last_num = par_wr_num;
      last_val = par_wr_val;
    end
    if (mic_cmd_valid === 1'b1) begin
      cmd_cnt++;
      last_cmd = mic_cmd_word;
    end
  end
  mmsx_remote #(.MAKER_ID(MK), .MODEL_ID(MD), .MIC_LEN(ML)) dut (
    .clk(clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready),
    .cfg_bank(3'h3), .cfg_dev_id(3'h5), .meter_level(meter_level), .meter_valid(meter_valid),
    .status_bytes(status_bytes), .mic_rd_data(mic_rd_data), .tx_data(tx_data), .tx_valid(tx_valid),
    .par_wr_valid(par_wr_valid), .par_wr_num(par_wr_num), .par_wr_val(par_wr_val),
    .mic_cmd_valid(mic_cmd_valid), .mic_cmd_word(mic_cmd_word), .mic_rd_ch(mic_rd_ch),
    .mic_rd_idx(mic_rd_idx));
  mmsx_host_model hm (
    .clk(clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid), .stall(stall), .tx_ready(tx_ready));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Controller keeps addresses legal and requests bodiless
  task automatic msg(input logic [7:0] a, input logic [7:0] ty, input logic [7:0] body [$]);
    logic [7:0] q [$];
    q = {mmsx_pkg::SOX, MK[23:16], MK[15:8], MK[7:0], MD, a, ty};
    q = {q, body, mmsx_pkg::EOX};
    base = hm.cnt;
    foreach (q[i]) begin
      rx_data  <= q[i];
      rx_valid <= 1'b1;
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic reply(input int n, input logic [7:0] ty);
    int k;
    for (k = 0; k < 2000 && hm.cnt < base + n; k++) @(posedge clk);
    if (hm.cnt < base + n) begin
      mismatches++;
      $display("MISMATCH t=%0t reply timed out", $time);
      end_sim();
    end
    repeat (6) @(posedge clk);
    chk(hm.cnt - base, n);
    chk(hm.got[base], mmsx_pkg::SOX);
    chk(hm.got[base + 5], ADDR);
    chk(hm.got[base + 6], ty);
    chk(hm.got[base + n - 1], mmsx_pkg::EOX);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_set();
    msg(ADDR, mmsx_pkg::TY_SET_IFACE, '{8'h02, 8'h2A, 8'h00, 8'h40, 8'h00, 8'h3F});
    chk(wr_cnt, 2);
    chk({last_num, last_val}, {7'h00, 7'h3F});
    msg(8'h36, mmsx_pkg::TY_SET_IFACE, '{8'h04, 8'h11});
    msg(8'h25, mmsx_pkg::TY_SET_IFACE, '{8'h04, 8'h11});
    chk(wr_cnt, 2);
    msg(mmsx_pkg::BCAST_ADDR, mmsx_pkg::TY_SET_IFACE, '{8'h04, 8'h01});
    chk({last_num, last_val}, {7'h04, 7'h01});
    msg(ADDR, mmsx_pkg::TY_SET_MIC, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
    chk(cmd_cnt, 1);
    chk(last_cmd, {7'h01, 7'h02, 7'h03, 7'h04});
    $display("test set done");
  endtask
  task automatic t_meter();
    for (int i = 0; i < 8; i++) meter_level[7*i +: 7] <= 7'(i * 9 + 5);
    meter_valid <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) meter_level[7*i +: 7] <= 7'(i + 1);
    @(posedge clk);
    meter_valid <= 1'b0;
    msg(mmsx_pkg::BCAST_ADDR, mmsx_pkg::TY_REQ_METER, nob);
    reply(16, mmsx_pkg::TY_RSP_METER);
    for (int i = 0; i < 8; i++) chk(hm.got[base + 7 + i], 8'(i * 9 + 5));
    msg(ADDR, mmsx_pkg::TY_REQ_METER, nob);
    reply(16, mmsx_pkg::TY_RSP_METER);
    for (int i = 0; i < 8; i++) chk(hm.got[base + 7 + i], 8'h00);
    $display("test meter done");
  endtask
  task automatic t_iface();
    stall        <= 1'b1;
    status_bytes <= {6{7'h15}};
    msg(ADDR, mmsx_pkg::TY_REQ_IFACE, nob);
    reply(37, mmsx_pkg::TY_RSP_IFACE);
    chk(hm.got[base + 9], 8'h2A);
    chk(hm.got[base + 11], 8'h01);
    chk(hm.got[base + 25], 8'h15);
    chk(hm.got[base + 35], 8'h00);
    stall <= 1'b0;
    $display("test iface done");
  endtask
  task automatic t_mic();
    msg(ADDR, 8'h45, nob);
    reply(ML + 8, mmsx_pkg::TY_RSP_MIC);
    for (int i = 0; i < ML; i++) chk(hm.got[base + 7 + i], {1'b0, 3'h5, 4'(i)});
    $display("test mic done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_set();
    t_meter();
    t_iface();
    t_mic();
    end_sim();
  end
endmodule
